// ===== bsc_pkg.sv
// Shared constants, types and helpers of the bridge command block.
// Assumes a byte-level link layer and a byte-level I2C engine on one clock.
`default_nettype none

package bsc_pkg;

   // Device command codes
   localparam logic [7:0] CMD_WR_CFG = 8'hD2;
   localparam logic [7:0] CMD_RD_CFG = 8'hE1;
   localparam logic [7:0] CMD_SLEEP = 8'h1E;
   localparam logic [7:0] CMD_RD_REV = 8'hC3;
   localparam logic [7:0] CMD_WR_RD = 8'h2D;

   // Result byte bit positions
   localparam int RES_CRC_BIT = 0;
   localparam int RES_ADDR_BIT = 1;
   localparam int RES_START_BIT = 3;

   // Write status values
   localparam logic [7:0] WSTAT_ALL_ACK = 8'h00;
   localparam logic [7:0] WSTAT_INVALID = 8'hFF;

   // Speed configuration: reset value, writable field, rate codes
   localparam logic [7:0] CFG_RESET = 8'h01;
   localparam logic [7:0] CFG_SPD_MASK = 8'h03;
   localparam logic [1:0] SPD_100K = 2'h0;
   localparam logic [1:0] SPD_400K = 2'h1;
   localparam logic [1:0] SPD_900K = 2'h2;

   // Reflected form of x^16 + x^15 + x^2 + 1
   localparam logic [15:0] CRC16_POLY_REFL = 16'hA001;
   localparam logic [15:0] CRC16_INIT = 16'h0000;

   // Buffer memory: write bytes in low half, read bytes in high half
   localparam int MEM_ADDR_W = 9;
   localparam logic WR_HALF = 1'h0;
   localparam logic RD_HALF = 1'h1;

   // I2C engine operations
   localparam logic [2:0] OP_START = 3'h0;
   localparam logic [2:0] OP_WRITE = 3'h1;
   localparam logic [2:0] OP_RSTART = 3'h2;
   localparam logic [2:0] OP_READ = 3'h3;
   localparam logic [2:0] OP_STOP = 3'h4;

   // Controller states, one-hot
   typedef enum logic [18:0] {
      S_IDLE = 19'h00001,
      S_CFG = 19'h00002,
      S_ADDR = 19'h00004,
      S_WLEN = 19'h00008,
      S_WDATA = 19'h00010,
      S_RLEN = 19'h00020,
      S_CRCL = 19'h00040,
      S_CRCH = 19'h00080,
      S_ST = 19'h00100,
      S_AW = 19'h00200,
      S_WR = 19'h00400,
      S_RS = 19'h00800,
      S_AR = 19'h01000,
      S_RD = 19'h02000,
      S_SP = 19'h04000,
      S_REPLY = 19'h08000,
      S_ONE = 19'h10000,
      S_WAITR = 19'h20000,
      S_SLEEP = 19'h40000
   } bsc_state_t;

   // Request to the I2C engine
   typedef struct packed {
      logic [2:0] op;   // Operation code
      logic [7:0] data; // Byte to send
      logic nack;       // Answer this read byte with NACK
   } bsc_i2c_cmd_t;

   // Answer from the I2C engine
   typedef struct packed {
      logic done;       // One-cycle completion pulse
      logic ack;        // Slave acknowledged the byte
      logic start_err;  // Start condition could not be made
      logic [7:0] rdata; // Byte read
   } bsc_i2c_rsp_t;

   // One byte step of the packet CRC, LSB first
   function automatic logic [15:0] bsc_crc16(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ d[i]) begin
            r = (r >> 1) ^ CRC16_POLY_REFL;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction

   // Index reaches the last of a length
   function automatic logic bsc_is_last(input logic [7:0] idx, input logic [7:0] len);
      return idx == (len - 8'h01);
   endfunction

endpackage

`default_nettype wire

// ===== bsc_mem.sv
// Small byte memory with registered read data.
// Assumes one clock; contents are undefined after reset.
`timescale 1ns/1ps
`default_nettype none

module bsc_mem #(
   parameter int ADDR_W = 9,
   parameter int DATA_W = 8
) (
   input wire logic clk_sys_in,
   input wire logic wr_en_in,
   input wire logic [ADDR_W-1:0] wr_addr_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   input wire logic [ADDR_W-1:0] rd_addr_in,
   output logic [DATA_W-1:0] rd_data_out
);

   // Storage array, no reset so it maps onto RAM
   logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];

   // Write port and registered read port
   always_ff @(posedge clk_sys_in) begin
      if (wr_en_in) begin
         store[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= store[rd_addr_in];
   end

endmodule

`default_nettype wire

// ===== bsc_bridge.sv
// Command interpreter of the serial-to-I2C bridge: packets, CRC, status, config, sleep.
// Assumes a link layer on clk_sys_in delivering bytes after a ROM-level selection,
// and a byte-level I2C engine answering each request with a done pulse.
`timescale 1ns/1ps
`default_nettype none

module bsc_bridge #(
   parameter logic [3:0] REV_MAJOR = 4'h1, // Arbitrary neutral value
   parameter logic [3:0] REV_MINOR = 4'h0  // Arbitrary neutral value
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_data_in,
   input wire logic bus_reset_in,
   input wire logic bit_slot_in,
   output logic tx_valid_out,
   output logic [7:0] tx_data_out,
   input wire logic tx_ready_in,
   output logic i2c_req_out,
   output bsc_pkg::bsc_i2c_cmd_t i2c_cmd_out,
   input wire bsc_pkg::bsc_i2c_rsp_t i2c_rsp_in,
   input wire logic wake_in,
   input wire logic sleep_req_in,
   output logic busy_out,
   output logic asleep_out,
   output logic error_flag_output_out,
   output logic [1:0] bus_rate_select_out
);
   import bsc_pkg::*;

   bsc_state_t state, next_state; // Controller state
   logic [7:0] cfg;         // Speed configuration
   logic [7:0] result;      // I2C result flags
   logic [7:0] wstat;       // Write NACK index
   logic len_err;           // Zero length seen
   logic [15:0] crc;        // Running packet CRC
   logic [7:0] crc_lo;      // First received CRC byte
   logic [7:0] addr;        // Slave address byte
   logic [7:0] wlen, rlen;  // Packet lengths
   logic [7:0] cnt;         // Byte index
   logic [1:0] rphase;      // Reply: 0 result, 1 wstat, 2 data
   logic [7:0] one_data;    // Single reply byte
   logic settle;            // Memory read data has settled
   logic zero_seen;         // Host read the 0b slot
   logic occ1;              // Second buffer entry full
   logic [7:0] buf1;        // Second buffer entry
   logic wake_meta, wake_sync, wake_prev; // Wake pin synchroniser
   logic slp_meta, slp_sync;              // Sleep pin synchroniser
   logic [7:0] mem_rd;      // Memory read data

   // Decoded conditions
   wire in_i2c = state inside {S_ST, S_AW, S_WR, S_RS, S_AR, S_RD, S_SP};
   wire listen = state inside {S_IDLE, S_CFG, S_ADDR, S_WLEN, S_WDATA, S_RLEN, S_CRCL, S_CRCH};
   wire rx_take = rx_valid_in && listen;
   wire done = i2c_req_out && i2c_rsp_in.done;
   wire ack = i2c_rsp_in.ack;
   wire rst_ok = bus_reset_in && !in_i2c && state != S_SLEEP;
   wire wake_rise = wake_sync && !wake_prev;
   wire last_w = bsc_is_last(cnt, wlen);
   wire last_r = bsc_is_last(cnt, rlen);
   wire len_zero = rx_data_in == 8'h00;
   wire crc_good = {rx_data_in, crc_lo} == ~crc;
   wire room = !occ1;
   wire fire = in_i2c && !i2c_req_out && settle;
   wire push_reply = state == S_REPLY && settle && zero_seen && room;
   wire push = push_reply || (state == S_ONE && room);
   wire [7:0] reply_byte = rphase == 2'h0 ? result : (rphase == 2'h1 ? wstat : mem_rd);
   wire [7:0] push_data = state == S_ONE ? one_data : reply_byte;
   wire pop = tx_valid_out && tx_ready_in;
   wire enter_reply = (state == S_CRCH && rx_take && !crc_good) || (state == S_SP && done);
   wire [7:0] addr_w = {addr[7:1], 1'h0};
   wire [7:0] addr_r = {addr[7:1], 1'h1};
   wire [7:0] cnt_inc = cnt + 8'h01;

   // Memory hookup: packet write bytes, then I2C read bytes
   wire mem_we = (state == S_WDATA && rx_take) || (state == S_RD && done);
   wire [MEM_ADDR_W-1:0] mem_wa = {state == S_RD ? RD_HALF : WR_HALF, cnt};
   wire [7:0] mem_wd = state == S_RD ? i2c_rsp_in.rdata : rx_data_in;
   wire [MEM_ADDR_W-1:0] mem_ra = {state == S_REPLY ? RD_HALF : WR_HALF, cnt};

   // result flags raised by CRC and I2C outcomes
   wire [7:0] res_set = {4'h0,
      state == S_ST && done && i2c_rsp_in.start_err, 1'h0,
      (state == S_AW || state == S_AR) && done && !ack,
      state == S_CRCH && rx_take && !crc_good};
   wire [7:0] next_result = (rst_ok ? 8'h00 : result) | res_set;
   wire next_len_err = (rst_ok ? 1'h0 : len_err) ||
      ((state == S_WLEN || state == S_RLEN) && rx_take && len_zero);
   wire next_settle = settle ? !(fire || push_reply) && (in_i2c || state == S_REPLY)
                             : (in_i2c && !i2c_req_out) || state == S_REPLY;

   bsc_mem #(.ADDR_W(MEM_ADDR_W), .DATA_W(8)) u_mem (
      .clk_sys_in(clk_sys_in),
      .wr_en_in(mem_we),
      .wr_addr_in(mem_wa),
      .wr_data_in(mem_wd),
      .rd_addr_in(mem_ra),
      .rd_data_out(mem_rd)
   );

   // Next state of the command sequence
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (rx_take) begin
               case (rx_data_in)
                  CMD_WR_CFG: next_state = S_CFG;
                  CMD_RD_CFG, CMD_RD_REV: next_state = S_ONE;
                  CMD_SLEEP: next_state = S_SLEEP;
                  CMD_WR_RD: next_state = S_ADDR;
                  default: next_state = S_WAITR; // Unknown: wait for reset
               endcase
            end
         end
         S_CFG: if (rx_take) next_state = S_IDLE;
         S_ADDR: if (rx_take) next_state = S_WLEN;
         S_WLEN: if (rx_take) next_state = len_zero ? S_WAITR : S_WDATA;
         S_WDATA: if (rx_take && last_w) next_state = S_RLEN;
         S_RLEN: if (rx_take) next_state = len_zero ? S_WAITR : S_CRCL;
         S_CRCL: if (rx_take) next_state = S_CRCH;
         S_CRCH: if (rx_take) next_state = crc_good ? S_ST : S_REPLY;
         // start, address, writes, restart, address, reads, stop
         S_ST: if (done) next_state = i2c_rsp_in.start_err ? S_SP : S_AW;
         S_AW: if (done) next_state = ack ? S_WR : S_SP;
         S_WR: if (done) next_state = !ack ? S_SP : (last_w ? S_RS : S_WR);
         S_RS: if (done) next_state = S_AR;
         S_AR: if (done) next_state = ack ? S_RD : S_SP;
         S_RD: if (done && last_r) next_state = S_SP;
         S_SP: if (done) next_state = S_REPLY;
         S_REPLY: if (push_reply && rphase == 2'h2 && last_r) next_state = S_IDLE;
         S_ONE: if (push) next_state = S_IDLE;
         S_WAITR: next_state = S_WAITR;
         // only a wake edge leaves sleep
         S_SLEEP: if (wake_rise && !slp_sync) next_state = S_IDLE;
         default: next_state = S_IDLE;
      endcase
      if (rst_ok) begin
         next_state = S_IDLE;
      end
      // sleep pin, deferred while I2C runs
      if (slp_sync && !in_i2c) begin
         next_state = S_SLEEP;
      end
   end

   // State and pin synchronisers
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= S_IDLE;
         {wake_meta, wake_sync, wake_prev} <= 3'h0;
         {slp_meta, slp_sync} <= 2'h0;
      end else begin
         state <= next_state;
         {wake_meta, wake_sync, wake_prev} <= {wake_in, wake_meta, wake_sync};
         {slp_meta, slp_sync} <= {sleep_req_in, slp_meta};
      end
   end

   // Status, flags and pin-level outputs
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         result <= 8'h00;
         len_err <= 1'h0;
         error_flag_output_out <= 1'h0;
         busy_out <= 1'h0;
         asleep_out <= 1'h0;
         settle <= 1'h0;
         zero_seen <= 1'h0;
      end else begin
         result <= next_result;
         len_err <= next_len_err;
         error_flag_output_out <= (|next_result) || next_len_err;
         busy_out <= next_state inside {S_ST, S_AW, S_WR, S_RS, S_AR, S_RD, S_SP};
         asleep_out <= next_state == S_SLEEP;
         settle <= next_settle;
         // results wait for the 0b slot
         zero_seen <= state == S_REPLY && (zero_seen || bit_slot_in);
      end
   end

   // Configuration and single-byte replies
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cfg <= CFG_RESET;
         one_data <= 8'h00;
      end else begin
         // store the speed field of the byte after the write-config command
         if (state == S_CFG && rx_take) begin
            cfg <= rx_data_in & CFG_SPD_MASK;
         end
         if (state == S_IDLE && rx_take) begin
            one_data <= rx_data_in == CMD_RD_REV ? {REV_MAJOR, REV_MINOR} : cfg;
         end
      end
   end

   // speed field drives the engine rate
   assign bus_rate_select_out = cfg[1:0];

   // Packet capture, CRC and counters
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         crc <= CRC16_INIT;
         crc_lo <= 8'h00;
         addr <= 8'h00;
         wlen <= 8'h00;
         rlen <= 8'h00;
         cnt <= 8'h00;
         rphase <= 2'h0;
         wstat <= WSTAT_ALL_ACK;
      end else begin
         // CRC over command, address (LSB zero), lengths, data
         if (state == S_IDLE && rx_take) begin
            crc <= bsc_crc16(CRC16_INIT, rx_data_in);
            cnt <= 8'h00;
         end
         if (state == S_ADDR && rx_take) begin
            addr <= rx_data_in;
            crc <= bsc_crc16(crc, {rx_data_in[7:1], 1'h0});
         end
         if ((state == S_WLEN || state == S_WDATA || state == S_RLEN) && rx_take) begin
            crc <= bsc_crc16(crc, rx_data_in);
         end
         if (state == S_WLEN && rx_take) wlen <= rx_data_in;
         if (state == S_RLEN && rx_take) rlen <= rx_data_in;
         if (state == S_WDATA && rx_take) cnt <= last_w ? 8'h00 : cnt_inc;
         if (state == S_CRCL && rx_take) crc_lo <= rx_data_in;
         // CRC failure reports invalid write status
         if (state == S_CRCH && rx_take) begin
            wstat <= crc_good ? WSTAT_ALL_ACK : WSTAT_INVALID;
         end
         // start or write-address failure reports invalid write status
         if (done && ((state == S_ST && i2c_rsp_in.start_err) || (state == S_AW && !ack))) begin
            wstat <= WSTAT_INVALID;
         end
         if (state == S_WR && done) begin
            cnt <= (last_w || !ack) ? 8'h00 : cnt_inc;
            if (!ack) wstat <= cnt_inc;
         end
         if (state == S_RD && done) cnt <= cnt_inc;
         if (enter_reply) begin
            cnt <= 8'h00;
            rphase <= 2'h0;
         end
         if (push_reply) begin
            if (rphase != 2'h2) rphase <= rphase + 2'h1;
            else cnt <= cnt_inc;
         end
      end
   end

   // I2C engine request; one request outstanding at a time
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         i2c_req_out <= 1'h0;
         i2c_cmd_out <= '0;
      end else if (done) begin
         i2c_req_out <= 1'h0;
      end else if (fire) begin
         i2c_req_out <= 1'h1;
         i2c_cmd_out.nack <= state == S_RD && last_r;
         case (state)
            S_ST: i2c_cmd_out.op <= OP_START;
            S_AW: i2c_cmd_out.op <= OP_WRITE;
            S_WR: i2c_cmd_out.op <= OP_WRITE;
            S_RS: i2c_cmd_out.op <= OP_RSTART;
            S_AR: i2c_cmd_out.op <= OP_WRITE;
            S_RD: i2c_cmd_out.op <= OP_READ;
            default: i2c_cmd_out.op <= OP_STOP;
         endcase
         i2c_cmd_out.data <= state == S_AW ? addr_w : (state == S_AR ? addr_r : mem_rd);
      end
   end

   // Two-entry reply buffer; a stalled link holds bytes, never drops them
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         tx_valid_out <= 1'h0;
         tx_data_out <= 8'h00;
         occ1 <= 1'h0;
         buf1 <= 8'h00;
      end else if (push && pop) begin
         if (occ1) begin
            tx_data_out <= buf1;
            buf1 <= push_data;
         end else begin
            tx_data_out <= push_data;
         end
      end else if (push) begin
         if (!tx_valid_out) begin
            tx_valid_out <= 1'h1;
            tx_data_out <= push_data;
         end else begin
            occ1 <= 1'h1;
            buf1 <= push_data;
         end
      end else if (pop) begin
         tx_data_out <= buf1;
         tx_valid_out <= occ1;
         occ1 <= 1'h0;
      end
   end

   // Checks next to the logic
   property p_res_layout;
      @(posedge clk_sys_in) disable iff (sys_rst_in) result[7:4] == 4'h0 && result[2] == 1'h0;
   endproperty
   a_res_layout: assert property (p_res_layout) else $error("reserved result bit set");

   property p_ed;
      @(posedge clk_sys_in) disable iff (sys_rst_in) (|result) |-> error_flag_output_out;
   endproperty
   a_ed: assert property (p_ed) else $error("error output low with flags set");

   property p_crc_bad;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
         (state == S_CRCH && rx_take && !crc_good) |=>
            (state == S_REPLY && result[0] && wstat == 8'hFF && !i2c_req_out);
   endproperty
   a_crc_bad: assert property (p_crc_bad) else $error("bad CRC handled wrong");

   property p_addr_nack;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
         (state == S_AW && done && !ack) |=> (result[1] && wstat == 8'hFF && state == S_SP);
   endproperty
   a_addr_nack: assert property (p_addr_nack) else $error("address NACK handled wrong");

   property p_nack_idx;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
         (state == S_WR && done && !ack) |=> wstat == $past(cnt) + 8'h01;
   endproperty
   a_nack_idx: assert property (p_nack_idx) else $error("wrong NACK ordinal");

   property p_cfg_wr;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
         (state == S_CFG && rx_valid_in && !slp_sync) |=> cfg == {6'h00, $past(rx_data_in[1:0])};
   endproperty
   a_cfg_wr: assert property (p_cfg_wr) else $error("config not stored");

   property p_cfg_rd;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
         (state == S_IDLE && rx_valid_in && rx_data_in == 8'hE1 && !slp_sync && !bus_reset_in)
            |=> (state == S_ONE && one_data == cfg);
   endproperty
   a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");

   property p_sleep_cmd;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
         (state == S_IDLE && rx_valid_in && rx_data_in == 8'h1E && !bus_reset_in)
            |=> state == S_SLEEP ##0 asleep_out;
   endproperty
   a_sleep_cmd: assert property (p_sleep_cmd) else $error("sleep command ignored");

   property p_stay_asleep;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
         (state == S_SLEEP && !wake_rise) |=> state == S_SLEEP;
   endproperty
   a_stay_asleep: assert property (p_stay_asleep) else $error("left sleep without wake");

   property p_zero_len;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
         (state == S_WLEN && rx_valid_in && rx_data_in == 8'h00 && !slp_sync && !bus_reset_in)
            |=> (state == S_WAITR && error_flag_output_out);
   endproperty
   a_zero_len: assert property (p_zero_len) else $error("zero length not flagged");

   property p_slot_first;
      @(posedge clk_sys_in) disable iff (sys_rst_in) push_reply |-> zero_seen && !busy_out;
   endproperty
   a_slot_first: assert property (p_slot_first) else $error("result sent before 0b slot");

endmodule

`default_nettype wire

// ===== bsc_i2c_model.sv
// Behavioural I2C engine with one slave behind it, facing the bridge's request port.
// Assumes the bridge holds req and cmd steady until the edge after done.
`timescale 1ns/1ps
`default_nettype none

module bsc_i2c_model (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic i2c_req_in,
   input wire bsc_pkg::bsc_i2c_cmd_t i2c_cmd_in,
   input wire logic [3:0] delay_in,
   input wire logic addr_nack_in,
   input wire logic start_err_in,
   input wire logic [7:0] nack_at_in,
   output bsc_pkg::bsc_i2c_rsp_t i2c_rsp_out,
   output logic [7:0] wlast_out,
   output logic [7:0] starts_out
);
   import bsc_pkg::*;
   logic [3:0] cnt; // Cycles since request seen
   logic done;
   logic ack;
   logic [7:0] wcnt; // Bytes written since start, address is byte 0
   logic [7:0] rcnt;
   logic [7:0] last;
   logic nack_now;
   // Address or chosen data byte is refused
   assign nack_now = (wcnt == 8'h00) ? addr_nack_in : (wcnt == nack_at_in);
   // Read data off the done pulse is junk, never the last value
   assign i2c_rsp_out = '{done: done, ack: ack, start_err: start_err_in,
                          rdata: done ? last : ~last};
   // Answer each request after delay_in cycles
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         {cnt, done, ack, wcnt, rcnt, last, starts_out, wlast_out} <= '0;
      end else begin
         done <= 1'b0;
         cnt <= i2c_req_in ? cnt + 4'h1 : 4'h0;
         if (i2c_req_in && cnt == delay_in) begin
            done <= 1'b1;
            ack <= !(i2c_cmd_in.op == OP_WRITE && nack_now);
            last <= 8'hC0 + rcnt;
            if (i2c_cmd_in.op == OP_START) begin
               {wcnt, rcnt} <= '0;
               starts_out <= starts_out + 8'h01;
            end
            // Last byte put on the wire, address bytes included
            if (i2c_cmd_in.op == OP_WRITE) begin
               wcnt <= wcnt + 8'h01;
               wlast_out <= i2c_cmd_in.data;
            end
            if (i2c_cmd_in.op == OP_READ) rcnt <= rcnt + 8'h01;
         end
      end
   end
endmodule

`default_nettype wire

// ===== tb_serial_to_i2c_bridge_status_config.sv
// Self-checking bench for the bridge command block.
// Assumes bsc_pkg, bsc_bridge and bsc_i2c_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_serial_to_i2c_bridge_status_config;
   import bsc_pkg::*;
   logic clk_sys_in = 0, sys_rst_in = 1, rx_valid_in = 0, bus_reset_in = 0;
   logic bit_slot_in = 0, tx_ready_in = 1, wake_in = 0, sleep_req_in = 0, addr_nack = 0;
   logic strt_err = 0;
   logic [7:0] cfgv [4] = '{8'h00, 8'h02, 8'hFF, 8'h01};
   logic [7:0] rx_data_in = 8'h00, nack_at = 8'h00, b, s;
   logic [3:0] dly = 4'h3;
   logic tx_valid_out, i2c_req_out, busy_out, asleep_out, error_flag_output_out;
   logic [7:0] tx_data_out, starts, wlast;
   logic [1:0] bus_rate_select_out;
   bsc_i2c_cmd_t i2c_cmd_out;
   bsc_i2c_rsp_t i2c_rsp_in;
   int mismatches = 0, checked = 0;
   always #25 clk_sys_in = ~clk_sys_in;
   bsc_bridge #(.REV_MAJOR(4'h3), .REV_MINOR(4'h7)) dut (.clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in), .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
      .bus_reset_in(bus_reset_in), .bit_slot_in(bit_slot_in), .tx_valid_out(tx_valid_out),
      .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in), .i2c_req_out(i2c_req_out),
      .i2c_cmd_out(i2c_cmd_out), .i2c_rsp_in(i2c_rsp_in), .wake_in(wake_in),
      .sleep_req_in(sleep_req_in), .busy_out(busy_out), .asleep_out(asleep_out),
      .error_flag_output_out(error_flag_output_out), .bus_rate_select_out(bus_rate_select_out));
   bsc_i2c_model far (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .i2c_req_in(i2c_req_out), .i2c_cmd_in(i2c_cmd_out), .delay_in(dly),
      .addr_nack_in(addr_nack), .start_err_in(strt_err), .nack_at_in(nack_at),
      .i2c_rsp_out(i2c_rsp_in), .wlast_out(wlast), .starts_out(starts));
   // Inputs move 5 ns after each rising edge
   task automatic tick(int n = 1);
      repeat (n) begin @(posedge clk_sys_in); #5; end
   endtask
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // One idle edge after each byte so valid never toggles twice in a step
   task automatic send(logic [7:0] d);
      rx_valid_in = 1; rx_data_in = d; tick(); rx_valid_in = 0; tick();
   endtask
   // Bounded wait for a reply byte
   task automatic get(output logic [7:0] d);
      int n;
      for (n = 0; n < 60 && tx_valid_out !== 1'b1; n++) tick();
      if (n == 60) begin
         chk(8'(tx_valid_out), 8'h01);
         end_sim();
      end else begin
         d = tx_data_out;
         tick();
      end
   endtask
   // Host-side ROM CRC-8, reflected x^8 + x^5 + x^4 + 1, LSB first
   function automatic logic [7:0] crc8(logic [63:0] v, int nb);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < nb * 8; i++) c = (c[0] ^ v[i]) ? (c >> 1) ^ 8'h8C : c >> 1;
      return c;
   endfunction
   function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
      for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ CRC16_POLY_REFL : c >> 1;
      return c;
   endfunction
   // Whole write-then-read packet, slot poll, then a stalled reply
   task automatic xfer(logic [7:0] ad, logic [7:0] wl, logic bad);
      logic [15:0] c;
      logic [7:0] p[$];
      int n;
      p = {CMD_WR_RD, ad, wl};
      for (int i = 0; i < wl; i++) p.push_back(8'h30 + 8'(i));
      p.push_back(8'h02);
      c = CRC16_INIT;
      foreach (p[i]) c = crc_step(c, (i == 1) ? {p[i][7:1], 1'b0} : p[i]);
      c = ~c ^ {15'h0000, bad};
      foreach (p[i]) send(p[i]);
      send(c[7:0]);
      send(c[15:8]);
      tick(3);
      for (n = 0; n < 3000 && busy_out !== 1'b0; n++) tick();
      if (n == 3000) begin
         chk(8'(busy_out), 8'h00);
         end_sim();
      end else begin
         tx_ready_in = 0; bit_slot_in = 1; tick(); bit_slot_in = 0; tick(12); tx_ready_in = 1;
      end
   endtask
   task automatic bus_rst;
      bus_reset_in = 1; tick(); bus_reset_in = 0; tick(2);
      chk(8'(error_flag_output_out), 8'h00);
   endtask
   initial begin
      tick(4); sys_rst_in = 0; tick(3);
      chk(8'(bus_rate_select_out), 8'(SPD_400K));
      foreach (cfgv[i]) begin
         s = cfgv[i];
         send(CMD_WR_CFG); send(s); tick(2);
         chk(8'(bus_rate_select_out), s & CFG_SPD_MASK);
         send(CMD_RD_CFG); get(b); chk(b, s & CFG_SPD_MASK);
      end
      send(CMD_RD_REV); get(b); chk(b, 8'h37);
      chk(crc8({crc8(56'h0123456789ABCD, 7), 56'h0123456789ABCD}, 8), 8'h00);
      $display("test config and revision done");
      xfer(8'hA1, 8'h02, 1'b0);
      get(b); chk(b, 8'h00); get(b); chk(b, 8'h00);
      get(b); chk(b, 8'hC0); get(b); chk(b, 8'hC1);
      chk(wlast, 8'hA1);
      nack_at = 8'h02; dly = 4'h1;
      xfer(8'hA0, 8'h03, 1'b0); get(b); chk(b, 8'h00); get(b); chk(b, 8'h02);
      get(b); get(b); chk(8'(error_flag_output_out), 8'h00);
      chk(wlast, 8'h31);
      $display("test good transfers done");
      s = starts;
      xfer(8'hA0, 8'h01, 1'b1); get(b); chk(b, 8'h01); get(b); chk(b, 8'hFF);
      get(b); get(b); chk(starts, s); chk(8'(error_flag_output_out), 8'h01);
      bus_rst();
      addr_nack = 1; nack_at = 8'h00;
      xfer(8'hA1, 8'h01, 1'b0); get(b); chk(b, 8'h02); get(b); chk(b, 8'hFF);
      get(b); get(b); chk(8'(error_flag_output_out), 8'h01);
      chk(wlast, 8'hA0);
      bus_rst();
      addr_nack = 0; strt_err = 1;
      xfer(8'hA0, 8'h01, 1'b0); get(b); chk(b, 8'h08); get(b); chk(b, 8'hFF);
      get(b); get(b); strt_err = 0; bus_rst();
      send(8'h55); send(CMD_RD_CFG); tick(4); chk(8'(tx_valid_out), 8'h00);
      bus_rst();
      send(CMD_WR_RD); send(8'hA0); send(8'h00); tick(3);
      chk(8'(error_flag_output_out), 8'h01);
      bus_rst();
      $display("test error cases done");
      send(CMD_SLEEP); tick(2); chk(8'(asleep_out), 8'h01);
      send(CMD_RD_CFG); tick(10); chk(8'(tx_valid_out), 8'h00);
      chk(8'(asleep_out), 8'h01); wake_in = 1; tick(6); chk(8'(asleep_out), 8'h00);
      wake_in = 0; sleep_req_in = 1; tick(6); chk(8'(asleep_out), 8'h01);
      sleep_req_in = 0; tick(3); wake_in = 1; tick(6); chk(8'(asleep_out), 8'h00);
      $display("test sleep done");
      end_sim();
   end
endmodule

`default_nettype wire
